// file: hdl/memmap_pkg.sv
// Shared constants and carriers for the memory map, stack and data pointer block.
// Assumes a single 25 MHz clock domain shared with the CPU sequencer.
package memmap_pkg;
   localparam logic [7:0] sfr_stack_pointer = 8'h81;
   localparam logic [7:0] sfr_dp0_low = 8'h82;
   localparam logic [7:0] sfr_dp0_high = 8'h83;
   localparam logic [7:0] sfr_dp1_low = 8'h84;
   localparam logic [7:0] sfr_dp1_high = 8'h85;
   localparam logic [7:0] sfr_pointer_select = 8'h92;
   localparam logic [7:0] sfr_step_control = 8'h93;
   localparam logic [7:0] stack_reset = 8'h07;
   localparam logic [15:0] dp_reset = 16'h0000;
   localparam logic [15:0] reset_vector = 16'h0000;
   localparam logic [7:0] upper_half_base = 8'h80;
   localparam logic [7:0] bank_area_last = 8'h1f;
   localparam logic [7:0] bit_area_base = 8'h20;
   localparam int active_pointer_pos = 0;
   localparam int next_pointer_pos = 3;
   localparam int step_mode_lsb = 1;
   localparam int auto_step_pos = 0;
   localparam int extension_data_ram_bytes = 1536;
   localparam int extension_data_ram_sfr_bytes = 52;
   localparam int internal_data_ram_bytes = 256;
   localparam logic [7:0] protected_data = 8'h00;
   localparam int vector_count = 23;
   typedef enum logic [1:0] {
      step_inc1 = 2'b00,
      step_dec1 = 2'b01,
      step_inc2 = 2'b10,
      step_dec2 = 2'b11
   } step_mode_t;
   typedef enum logic [2:0] {
      op_none = 3'h0,
      op_push = 3'h1,
      op_pop = 3'h2,
      op_call = 3'h3,
      op_ret = 3'h4
   } stack_op_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic indirect;
      logic [7:0] addr;
      logic [7:0] wdata;
   } internal_data_ram_req_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;
   typedef struct packed {
      logic [7:0] stack_pointer;
      logic [15:0] dp0;
      logic [15:0] dp1;
      logic active_pointer;
      logic [3:0] step0;
      logic [3:0] step1;
      logic [7:0] sfr_rdata;
      logic sfr_hit;
      logic [7:0] internal_data_ram_rdata;
      logic [15:0] xaddr;
      logic [15:0] pc_load;
      logic pc_load_valid;
      logic [7:0] stack_addr;
      logic [7:0] code_rdata;
   } core_state_t;
endpackage

// file: hdl/vector_table.sv
// Fixed interrupt entry addresses by source index.
// Combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module vector_table (
   input wire logic [4:0] source,
   output logic [15:0] entry
);
   always_comb begin
      case (source)
         5'd0: entry = 16'h0003;
         5'd1: entry = 16'h000b;
         5'd2: entry = 16'h0013;
         5'd3: entry = 16'h001b;
         5'd4: entry = 16'h0023;
         5'd5: entry = 16'h002b;
         5'd6: entry = 16'h0033;
         5'd7: entry = 16'h003b;
         5'd8: entry = 16'h0043;
         5'd9: entry = 16'h004b;
         5'd10: entry = 16'h0053;
         5'd11: entry = 16'h005b;
         5'd12: entry = 16'h0063;
         5'd13: entry = 16'h006b;
         5'd14: entry = 16'h0083;
         5'd15: entry = 16'h008b;
         5'd16: entry = 16'h0093;
         5'd17: entry = 16'h00a3;
         5'd18: entry = 16'h00ab;
         5'd19: entry = 16'h00b3;
         5'd20: entry = 16'h00bb;
         5'd21: entry = 16'h00c3;
         5'd22: entry = 16'h00eb;
         default: entry = 16'h0003;
      endcase
   end
endmodule
`default_nettype wire

// file: hdl/byte_ram.sv
// Single-port byte RAM, synchronous write, registered read.
// Depth is fixed by the instantiating module.
`timescale 1ns/1ps
`default_nettype none
module byte_ram #(
   parameter int depth = 256,
   parameter int aw = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [aw-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [depth];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

// file: hdl/memory_map_core.sv
// Internal RAM decode, stack pointer, dual data pointers, vectors and code protection.
// Assumes the CPU sequencer issues at most one request of each kind per cycle.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// R1: Lower 128 internal bytes are ordinary RAM by direct and indirect access.
// R2: Upper 128: indirect goes to RAM, direct goes to special registers.
// R3: Bytes 00h-1Fh are four banks of R0-R7 chosen by bank bits.
// R4: Bytes 20h-2Fh give 128 bits; bit address is 8*offset plus index.
// R5: Stack pointer resets to 07h and software may load any value.
// R6: Push adds one to the stack pointer; pop subtracts one.
// R7: Call and interrupt entry use two bytes; return lowers pointer by two.
// R8: Every reset loads the program counter with 0000h.
// R9: Each interrupt source has its own fixed entry address 0003h..00EBh.
// R10: Software self-programs only 00ECh-7FBFh, never 7FC0h or above.
// R11: With protection on, external code read-out returns 00h everywhere.
// R12: 1536 bytes of extension RAM plus 52 special bytes via external moves.
// R13: Selected data pointer addresses external moves and table reads.
// R14: Two 16-bit pointers; select bit 0 picks first, 1 picks second.
// R15: After each external move the next-pointer bit loads the select bit.
// R16: Step field: 00 +1, 01 -1, 10 +2, 11 -2 after each move.
// R17: Step control register is banked per pointer, chosen by select bit.
// R18: Software sets alternation by programming both next-pointer bits crosswise.
// R19: Stepping happens only when the auto-step enable bit is one.
// R20: Push pre-increments, pop reads then decrements; pointer marks top byte.
// R21: Reserved select and step control bits read zero and ignore writes.
module memory_map_core (
   input wire logic clk,
   input wire logic rst_n,
   input wire memmap_pkg::internal_data_ram_req_t internal_data_ram_req,
   input wire logic [1:0] bank_select_bits,
   input wire logic [2:0] reg_index,
   input wire logic reg_access,
   input wire logic [6:0] bit_addr,
   input wire logic bit_access,
   input wire memmap_pkg::sfr_req_t sfr_req,
   input wire memmap_pkg::stack_op_t stack_op,
   input wire logic xmove,
   input wire logic code_read_ext,
   input wire logic [7:0] code_data,
   input wire logic protect_enable,
   input wire logic irq_take,
   input wire logic [4:0] irq_source,
   output logic [7:0] internal_data_ram_rdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   output logic [7:0] stack_addr,
   output logic [7:0] stack_pointer_reg,
   output logic [15:0] data_pointer,
   output logic [15:0] pc_load,
   output logic pc_load_valid,
   output logic [7:0] code_rdata
);
   memmap_pkg::core_state_t st;
   memmap_pkg::core_state_t next_st;
   logic [7:0] ram_addr;
   logic ram_we;
   logic [7:0] ram_q;
   logic [15:0] vec_entry;
   logic [15:0] cur_dp;
   logic [3:0] cur_step;
   logic [15:0] stepped;
   logic [7:0] sp_plus1;

   // One storage array for all 256 indirect bytes; direct writes to the upper half never reach it
   always_comb begin
      ram_addr = internal_data_ram_req.addr;
      if (reg_access) begin
         ram_addr = {3'b000, bank_select_bits, reg_index}; // see R3
      end else if (bit_access) begin
         ram_addr = memmap_pkg::bit_area_base + {4'h0, bit_addr[6:3]}; // see R4
      end else if (stack_op == memmap_pkg::op_push || stack_op == memmap_pkg::op_call) begin
         ram_addr = sp_plus1; // see R20
      end else if (stack_op == memmap_pkg::op_pop || stack_op == memmap_pkg::op_ret) begin
         ram_addr = st.stack_pointer; // see R20
      end
   end
   // Direct writes at 80h and up are blocked from the RAM array
   assign ram_we = internal_data_ram_req.valid && internal_data_ram_req.write
      && (internal_data_ram_req.indirect || internal_data_ram_req.addr < memmap_pkg::upper_half_base); // see R1 R2

   byte_ram #(.depth(memmap_pkg::internal_data_ram_bytes), .aw(8)) internal_data_ram_store (
      .clk(clk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(internal_data_ram_req.wdata),
      .rdata(ram_q)
   );

   vector_table vectors (
      .source(irq_source),
      .entry(vec_entry)
   );

   assign sp_plus1 = st.stack_pointer + 8'h01;
   assign cur_dp = st.active_pointer ? st.dp1 : st.dp0; // see R14
   assign cur_step = st.active_pointer ? st.step1 : st.step0; // see R17

   always_comb begin
      case (memmap_pkg::step_mode_t'(cur_step[2:1]))
         memmap_pkg::step_inc1: stepped = cur_dp + 16'h0001;
         memmap_pkg::step_dec1: stepped = cur_dp - 16'h0001;
         memmap_pkg::step_inc2: stepped = cur_dp + 16'h0002;
         default: stepped = cur_dp - 16'h0002;
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.pc_load_valid = 1'b0;
      next_st.internal_data_ram_rdata = ram_q;
      next_st.stack_addr = st.stack_pointer;
      next_st.code_rdata = protect_enable && code_read_ext ? memmap_pkg::protected_data : code_data; // see R11
      next_st.sfr_hit = 1'b0;
      next_st.sfr_rdata = 8'h00;
      if (sfr_req.valid) begin
         next_st.sfr_hit = 1'b1;
         if (sfr_req.addr == memmap_pkg::sfr_stack_pointer) begin
            next_st.sfr_rdata = st.stack_pointer;
         end else if (sfr_req.addr == memmap_pkg::sfr_dp0_low) begin
            next_st.sfr_rdata = st.dp0[7:0];
         end else if (sfr_req.addr == memmap_pkg::sfr_dp0_high) begin
            next_st.sfr_rdata = st.dp0[15:8];
         end else if (sfr_req.addr == memmap_pkg::sfr_dp1_low) begin
            next_st.sfr_rdata = st.dp1[7:0];
         end else if (sfr_req.addr == memmap_pkg::sfr_dp1_high) begin
            next_st.sfr_rdata = st.dp1[15:8];
         end else if (sfr_req.addr == memmap_pkg::sfr_pointer_select) begin
            next_st.sfr_rdata = {7'h00, st.active_pointer}; // see R21
         end else if (sfr_req.addr == memmap_pkg::sfr_step_control) begin
            next_st.sfr_rdata = {4'h0, cur_step}; // see R17 R21
         end else begin
            next_st.sfr_hit = 1'b0;
         end
      end
      // Stack motion; a direct software write below overrides it
      case (stack_op)
         memmap_pkg::op_push: next_st.stack_pointer = st.stack_pointer + 8'h01; // see R6
         memmap_pkg::op_pop: next_st.stack_pointer = st.stack_pointer - 8'h01; // see R6
         memmap_pkg::op_call: next_st.stack_pointer = st.stack_pointer + 8'h02; // see R7
         memmap_pkg::op_ret: next_st.stack_pointer = st.stack_pointer - 8'h02; // see R7
         default: next_st.stack_pointer = st.stack_pointer;
      endcase
      if (stack_op != memmap_pkg::op_none) begin
         next_st.stack_addr = (stack_op == memmap_pkg::op_push || stack_op == memmap_pkg::op_call)
            ? sp_plus1 : st.stack_pointer; // see R20
      end
      if (irq_take) begin
         next_st.stack_pointer = st.stack_pointer + 8'h02; // see R7
         next_st.pc_load = vec_entry; // see R9
         next_st.pc_load_valid = 1'b1;
      end
      // External move: step then swap, both after the access
      if (xmove) begin
         if (cur_step[memmap_pkg::auto_step_pos]) begin // see R19
            if (st.active_pointer) begin
               next_st.dp1 = stepped; // see R16
            end else begin
               next_st.dp0 = stepped; // see R16
            end
         end
         next_st.active_pointer = cur_step[memmap_pkg::next_pointer_pos]; // see R15
      end
      if (sfr_req.valid && sfr_req.write) begin
         if (sfr_req.addr == memmap_pkg::sfr_stack_pointer) begin
            next_st.stack_pointer = sfr_req.wdata; // see R5
         end else if (sfr_req.addr == memmap_pkg::sfr_dp0_low) begin
            next_st.dp0[7:0] = sfr_req.wdata;
         end else if (sfr_req.addr == memmap_pkg::sfr_dp0_high) begin
            next_st.dp0[15:8] = sfr_req.wdata;
         end else if (sfr_req.addr == memmap_pkg::sfr_dp1_low) begin
            next_st.dp1[7:0] = sfr_req.wdata;
         end else if (sfr_req.addr == memmap_pkg::sfr_dp1_high) begin
            next_st.dp1[15:8] = sfr_req.wdata;
         end else if (sfr_req.addr == memmap_pkg::sfr_pointer_select) begin
            next_st.active_pointer = sfr_req.wdata[memmap_pkg::active_pointer_pos]; // see R21
         end else if (sfr_req.addr == memmap_pkg::sfr_step_control) begin
            if (st.active_pointer) begin
               next_st.step1 = sfr_req.wdata[3:0]; // see R17 R21
            end else begin
               next_st.step0 = sfr_req.wdata[3:0]; // see R17 R21
            end
         end
      end
      // Extension RAM and its special bytes are reached only through this address
      next_st.xaddr = xmove ? cur_dp : next_st.active_pointer ? next_st.dp1 : next_st.dp0; // see R12 R13
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
         st.stack_pointer <= memmap_pkg::stack_reset; // see R5
         st.dp0 <= memmap_pkg::dp_reset;
         st.dp1 <= memmap_pkg::dp_reset;
         st.pc_load <= memmap_pkg::reset_vector; // see R8
         st.pc_load_valid <= 1'b1;
         st.stack_addr <= memmap_pkg::stack_reset;
      end else begin
         st <= next_st;
      end
   end

   // RAM read register already gives the one-cycle answer
   assign internal_data_ram_rdata = ram_q;
   assign sfr_rdata = st.sfr_rdata;
   assign sfr_hit = st.sfr_hit;
   assign stack_addr = st.stack_addr;
   assign stack_pointer_reg = st.stack_pointer;
   assign data_pointer = st.xaddr;
   assign pc_load = st.pc_load;
   assign pc_load_valid = st.pc_load_valid;
   assign code_rdata = st.code_rdata;

   a_sp_push: assert property (@(posedge clk) disable iff (!rst_n) // see R6
      stack_op == memmap_pkg::op_push && !irq_take && !(sfr_req.valid && sfr_req.write)
      |=> stack_pointer_reg == $past(stack_pointer_reg) + 8'h01) else $error("push step wrong");
   a_sp_pop: assert property (@(posedge clk) disable iff (!rst_n) // see R6
      stack_op == memmap_pkg::op_pop && !irq_take && !(sfr_req.valid && sfr_req.write)
      |=> stack_pointer_reg == $past(stack_pointer_reg) - 8'h01) else $error("pop step wrong");
   a_sp_ret: assert property (@(posedge clk) disable iff (!rst_n) // see R7
      stack_op == memmap_pkg::op_ret && !irq_take && !(sfr_req.valid && sfr_req.write)
      |=> stack_pointer_reg == $past(stack_pointer_reg) - 8'h02) else $error("return step wrong");
   a_sp_irq: assert property (@(posedge clk) disable iff (!rst_n) // see R7
      irq_take && !(sfr_req.valid && sfr_req.write)
      |=> stack_pointer_reg == $past(stack_pointer_reg) + 8'h02) else $error("irq stack wrong");
   a_reset_state: assert property (@(posedge clk) // see R5
      !rst_n |=> stack_pointer_reg == 8'h07 && pc_load == 16'h0000 && pc_load_valid)
      else $error("reset values wrong");
   a_protect_zero: assert property (@(posedge clk) disable iff (!rst_n) // see R11
      protect_enable && code_read_ext |=> code_rdata == 8'h00) else $error("protected read leaked");
   a_swap_next: assert property (@(posedge clk) disable iff (!rst_n) // see R15
      xmove && !(sfr_req.valid && sfr_req.write) |=> st.active_pointer == $past(cur_step[3]))
      else $error("pointer swap wrong");
   a_step_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R19
      xmove && !cur_step[0] && !(sfr_req.valid && sfr_req.write)
      |=> st.dp0 == $past(st.dp0) && st.dp1 == $past(st.dp1)) else $error("pointer moved while off");
   a_dir_upper: assert property (@(posedge clk) disable iff (!rst_n) // see R2
      internal_data_ram_req.valid && !internal_data_ram_req.indirect && internal_data_ram_req.addr >= 8'h80 |-> !ram_we)
      else $error("direct upper write hit RAM");
   a_sel_read: assert property (@(posedge clk) disable iff (!rst_n) // see R21
      sfr_req.valid && sfr_req.addr == 8'h92 |=> sfr_rdata[7:1] == 7'h00) else $error("reserved bits set");

   c_xmove_step: cover property (@(posedge clk) disable iff (!rst_n) xmove && cur_step[0]);
   c_irq: cover property (@(posedge clk) disable iff (!rst_n) irq_take);
   c_call_ret: cover property (@(posedge clk) disable iff (!rst_n)
      stack_op == memmap_pkg::op_call ##[1:20] stack_op == memmap_pkg::op_ret);
endmodule
`default_nettype wire

// file: tb/cpu_flash_model.sv
// Far-side model: the program memory seen by the sequencer for table reads.
// Assumes the table address is the block's registered data pointer output.
`timescale 1ns/1ps
`default_nettype none
module cpu_flash_model (
   input wire logic [15:0] table_addr,
   output logic [7:0] code_data
);
   // Content is a fixed function of the address, so each read is predictable
   assign code_data = table_addr[7:0] ^ table_addr[15:8] ^ 8'h5a;
   // Only table reads are issued here; no self-programming is attempted
endmodule
`default_nettype wire

// file: tb/test_memory_map_core.sv
// Self-checking bench for the memory map, stack and data pointer block.
// Assumes registered outputs valid one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module test_memory_map_core;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   memmap_pkg::internal_data_ram_req_t req = '0;
   memmap_pkg::sfr_req_t sfr = '0;
   memmap_pkg::stack_op_t op = memmap_pkg::op_none;
   logic [1:0] bank = 2'h0;
   logic [2:0] ridx = 3'h0;
   logic racc = 1'b0;
   logic [6:0] baddr = 7'h00;
   logic bacc = 1'b0;
   logic xmove = 1'b0;
   logic cread = 1'b0;
   logic prot = 1'b0;
   logic irq = 1'b0;
   logic [4:0] isrc = 5'h00;
   logic [7:0] code_data, internal_data_ram_rdata, sfr_rdata, stack_addr, stack_pointer_reg, code_rdata;
   logic sfr_hit, pc_load_valid;
   logic [15:0] data_pointer, pc_load;
   int fails = 0;
   int cmp_count = 0;
   memory_map_core i_memory_map_core (.clk(clk), .rst_n(rst_n), .internal_data_ram_req(req),
      .bank_select_bits(bank), .reg_index(ridx), .reg_access(racc), .bit_addr(baddr),
      .bit_access(bacc), .sfr_req(sfr), .stack_op(op), .xmove(xmove), .code_read_ext(cread),
      .code_data(code_data), .protect_enable(prot), .irq_take(irq), .irq_source(isrc),
      .internal_data_ram_rdata(internal_data_ram_rdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .stack_addr(stack_addr),
      .stack_pointer_reg(stack_pointer_reg), .data_pointer(data_pointer), .pc_load(pc_load),
      .pc_load_valid(pc_load_valid), .code_rdata(code_rdata));
   cpu_flash_model i_cpu_flash_model (.table_addr(data_pointer), .code_data(code_data));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // One request cycle: inputs were set off the edge, answer is read at the next falling edge
   task automatic tick;
      @(negedge clk);
      req = '0;
      sfr = '0;
      op = memmap_pkg::op_none;
      {racc, bacc, xmove, cread, irq} = 5'h00;
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfr = '{1'b1, 1'b1, a, d};
      tick();
   endtask
   task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e, input logic h);
      sfr = '{1'b1, 1'b0, a, 8'h00};
      tick();
      `CHK("sfr_hit", h, sfr_hit);
      `CHK("sfr_rdata", e, sfr_rdata);
   endtask
   task automatic stk(input memmap_pkg::stack_op_t o, input logic [7:0] d, input logic [7:0] e);
      logic [7:0] ea;
      ea = (o == memmap_pkg::op_push) ? e : (o == memmap_pkg::op_call) ? e - 8'h01
         : (o == memmap_pkg::op_pop) ? e + 8'h01 : e + 8'h02;
      op = o;
      req = '{(o == memmap_pkg::op_push || o == memmap_pkg::op_pop), (o == memmap_pkg::op_push),
         1'b1, 8'h00, d};
      tick();
      `CHK("stack_pointer", e, stack_pointer_reg);
      `CHK("stack_addr", ea, stack_addr);
   endtask
   task automatic ram(input logic w, input logic ind, input logic [7:0] a, input logic [7:0] d);
      req = '{1'b1, w, ind, a, d};
      tick();
   endtask
   task automatic t_reset;
      `CHK("pc_load", 16'h0000, pc_load);
      `CHK("stack_pointer", 8'h07, stack_pointer_reg);
      sfr_chk(8'h81, 8'h07, 1'b1);
      sfr_chk(8'h82, 8'h00, 1'b1);
      sfr_chk(8'h85, 8'h00, 1'b1);
      sfr_chk(8'h92, 8'h00, 1'b1);
      sfr_chk(8'h93, 8'h00, 1'b1);
      sfr_chk(8'h86, 8'h00, 1'b0);
   endtask
   task automatic t_stack;
      stk(memmap_pkg::op_push, 8'h3c, 8'h08);
      stk(memmap_pkg::op_push, 8'h4d, 8'h09);
      stk(memmap_pkg::op_pop, 8'h00, 8'h08);
      `CHK("pop_data", 8'h4d, internal_data_ram_rdata);
      stk(memmap_pkg::op_call, 8'h00, 8'h0a);
      stk(memmap_pkg::op_ret, 8'h00, 8'h08);
      irq = 1'b1;
      isrc = 5'd0;
      tick();
      `CHK("irq_sp", 8'h0a, stack_pointer_reg);
      `CHK("vector_first", 16'h0003, pc_load);
      irq = 1'b1;
      isrc = 5'd22;
      tick();
      `CHK("vector_last", 16'h00eb, pc_load);
      sfr_wr(8'h81, 8'hbf);
      stk(memmap_pkg::op_push, 8'h11, 8'hc0);
   endtask
   task automatic t_internal_data_ram;
      ram(1'b1, 1'b0, 8'h28, 8'h5c);
      ram(1'b1, 1'b0, 8'h13, 8'he1);
      ram(1'b1, 1'b1, 8'h90, 8'ha5);
      ram(1'b1, 1'b0, 8'h90, 8'h3e);
      ram(1'b0, 1'b1, 8'h90, 8'h00);
      `CHK("upper_indirect", 8'ha5, internal_data_ram_rdata);
      ram(1'b0, 1'b1, 8'h13, 8'h00);
      `CHK("lower_indirect", 8'he1, internal_data_ram_rdata);
      bank = 2'h2;
      ridx = 3'h3;
      racc = 1'b1;
      ram(1'b0, 1'b0, 8'h00, 8'h00);
      `CHK("bank_reg", 8'he1, internal_data_ram_rdata);
      baddr = 7'h42;
      bacc = 1'b1;
      ram(1'b0, 1'b0, 8'h00, 8'h00);
      `CHK("bit_byte", 8'h5c, internal_data_ram_rdata);
   endtask
   task automatic t_data_pointer;
      logic [7:0] md [3] = '{8'h07, 8'h00, 8'h01};
      logic [15:0] ex [3] = '{16'h1234, 16'h1234, 16'h1235};
      sfr_wr(8'h92, 8'hff);
      sfr_chk(8'h92, 8'h01, 1'b1);
      sfr_wr(8'h93, 8'hff);
      sfr_chk(8'h93, 8'h0f, 1'b1);
      sfr_wr(8'h84, 8'h00);
      sfr_wr(8'h85, 8'h01);
      sfr_wr(8'h93, 8'h03);
      sfr_wr(8'h92, 8'h00);
      sfr_wr(8'h82, 8'h34);
      sfr_wr(8'h83, 8'h12);
      sfr_wr(8'h93, 8'h0d);
      cread = 1'b1;
      tick();
      `CHK("table_read", 8'h7c, code_rdata);
      {cread, prot} = 2'b11;
      tick();
      `CHK("protected_read", 8'h00, code_rdata);
      xmove = 1'b1;
      tick();
      `CHK("used_pointer0", 16'h1234, data_pointer);
      sfr_chk(8'h92, 8'h01, 1'b1);
      sfr_chk(8'h82, 8'h36, 1'b1);
      sfr_chk(8'h93, 8'h03, 1'b1);
      xmove = 1'b1;
      tick();
      `CHK("used_pointer1", 16'h0100, data_pointer);
      sfr_chk(8'h92, 8'h00, 1'b1);
      sfr_chk(8'h84, 8'hff, 1'b1);
      sfr_chk(8'h85, 8'h00, 1'b1);
      for (int i = 0; i < 3; i++) begin
         sfr_wr(8'h93, md[i]);
         xmove = 1'b1;
         tick();
         tick();
         `CHK("stepped_pointer", ex[i], data_pointer);
      end
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      tick();
      t_reset();
      t_stack();
      t_internal_data_ram();
      t_data_pointer();
      finish_test();
   end
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      finish_test();
   end
endmodule
`default_nettype wire
